//--- hdl/rcpd_dimmer.sv
// RGB channel PWM dimmer: colour and brightness registers, duty
// multiply, 9-bit PWM with 3-bit dithering, power-save qualify and
// enable-pin sequencing.
// Assumes the serial bus front end presents byte accesses on REG_*
// in the CLK_SYS domain; the EN pin is asynchronous.
// Operation
// - 18 or 24 sink channels, each own PWM
// - Every channel has own 8-bit colour register
// - Triplets share brightness; module n uses 3n..3n+2
// - Brightness register gives 256 intensity steps
// - Brightness resets to ff, meaning full factor
// - Global bit selects log or linear brightness
// - Duty equals colour times scaled brightness
// - 12-bit duty: 9-bit width plus 3-bit fraction
// - Dither lengthens fraction pulses in eight periods
// - Dither enable default on; off ignores fraction
// - PWM switching frequency nominally 29 kHz; 13 x 512 clocks at 200 MHz gives about 30 kHz
// - Outputs off 30 ms before power save
// - Bus accepted within 500 us of EN rise
// - Bus interface reset within 3 us EN fall
// - Power save only when enabled, all off
`timescale 1ns/1ps
`default_nettype none
module rcpd_dimmer
  import rcpd_pkg::*;
#(
  parameter int unsigned CHANNELS = CH_HIGH,
  parameter int unsigned PSM_CYCLES = PSM_CYC,
  parameter int unsigned EN_H_CYCLES = EN_H_CYC
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic EN,
  input wire logic REG_STB,
  input wire logic REG_WR,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic LOG_SCALE_EN,
  input wire logic DITHER_EN,
  input wire logic PSAVE_EN,
  output logic BUS_READY,
  output logic BUS_RESET,
  output logic POWER_SAVE,
  output logic [NUM_CH-1:0] SINK_OUTPUT_CHANNEL
);
  // ==========================================
  // State record
  // ==========================================
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] colour;   // Per-channel colour
    logic [NUM_MOD-1:0][7:0] bright;  // Per-module brightness
    logic [1:0] en_sync;              // Pin synchroniser
    logic [EN_CW-1:0] en_cnt;         // Wake-up counter
    logic ready;                      // Bus accesses accepted
    logic [7:0] rdata;                // Read answer
    logic [3:0] pre;                  // Step prescaler
    logic [8:0] cnt;                  // PWM step counter
    logic [2:0] frame;                // Dither period index
    logic [NUM_CH-1:0] out;           // Sink drive
    logic [PSM_CW-1:0] psm_cnt;       // Idle qualify counter
    logic psave;                      // In power save
  } rcpd_state_t;

  rcpd_state_t r_reg;
  rcpd_state_t r_next;

  // ==========================================
  // Helpers
  // ==========================================
  // Log curve as 2^(b/32): exponent in top bits, mantissa below.
  // Cheap in gates, monotonic, and pinned so ff stays full scale.
  function automatic logic [7:0] bright_factor(input logic [7:0] b,
                                               input logic log_en);
    logic [12:0] v;
    v = 13'({1'b1, b[4:0]}) << b[7:5];
    if (!log_en) begin
      bright_factor = b;
    end else if (b == 8'hff) begin
      bright_factor = 8'hff;
    end else begin
      bright_factor = v[12:5];
    end
  endfunction

  // Product rescaled so that ff x ff lands on fff and 0 stays 0.
  function automatic logic [11:0] duty_of(input logic [7:0] c,
                                          input logic [7:0] f);
    logic [16:0] p;
    p = 17'(c * f);
    p = p + (p >> 7);
    duty_of = p[15:4];
  endfunction

  // ==========================================
  // Next-state logic
  // ==========================================
  // Single combinational pass; every field starts from its old value.
  always_comb begin
    logic en;
    logic acc;
    logic tick;
    logic all_off;
    logic [5:0] ci;
    logic [5:0] bi;
    logic [7:0] f;
    logic [11:0] d;
    logic [9:0] width;
    en = 1'b0;
    acc = 1'b0;
    tick = 1'b0;
    all_off = 1'b1;
    ci = 6'h00;
    bi = 6'h00;
    f = 8'h00;
    d = 12'h000;
    width = 10'h000;
    r_next = r_reg;
    // Pin synchroniser: second stage is the only reader
    r_next.en_sync = {r_reg.en_sync[0], EN};
    en = r_reg.en_sync[1];
    acc = REG_STB && r_reg.ready;
    ci = REG_ADDR - COLOUR_BASE;
    bi = REG_ADDR - BRIGHT_BASE;
    // Wake-up window after EN rises
    if (!r_reg.ready && r_reg.en_cnt == EN_CW'(EN_H_CYCLES - 1)) begin
      r_next.ready = 1'b1;
    end else if (!r_reg.ready) begin
      r_next.en_cnt = r_reg.en_cnt + EN_CW'(1);
    end
    // Register access; ignored until ready
    if (acc && REG_WR) begin
      if (REG_ADDR >= COLOUR_BASE && ci < 6'(NUM_CH)) begin
        r_next.colour[ci[4:0]] = REG_WDATA;
      end else if (bi < 6'(NUM_MOD)) begin
        r_next.bright[bi[2:0]] = REG_WDATA;
      end
    end else if (acc) begin
      if (REG_ADDR >= COLOUR_BASE && ci < 6'(NUM_CH)) begin
        r_next.rdata = r_reg.colour[ci[4:0]];
      end else if (bi < 6'(NUM_MOD)) begin
        r_next.rdata = r_reg.bright[bi[2:0]];
      end else begin
        r_next.rdata = UNMAPPED_RD; // Unmapped answers zero
      end
    end
    // Step prescaler and 512-step period
    tick = (r_reg.pre == PRE_LAST);
    r_next.pre = tick ? 4'h0 : r_reg.pre + 4'h1;
    if (tick) begin
      r_next.cnt = r_reg.cnt + 9'h001;
      if (r_reg.cnt == PWM_LAST) begin
        r_next.frame = r_reg.frame + 3'h1;
      end
    end
    // Per-channel duty and compare
    for (int i = 0; i < NUM_CH; i++) begin
      f = bright_factor(r_reg.bright[i / 3], LOG_SCALE_EN);
      d = duty_of(r_reg.colour[i], f);
      width = {1'b0, d[11:3]};
      if (DITHER_EN && r_reg.frame < d[2:0]) begin
        width = width + 10'h001;
      end
      if (i < CHANNELS) begin
        r_next.out[i] = ({1'b0, r_reg.cnt} < width);
        all_off = all_off && (d == 12'h000);
      end else begin
        r_next.out[i] = 1'b0;
      end
    end
    // Idle qualification for power save
    if (!all_off || acc || !PSAVE_EN) begin
      r_next.psm_cnt = '0;
      r_next.psave = 1'b0;
    end else if (r_reg.psm_cnt == PSM_CW'(PSM_CYCLES - 1)) begin
      r_next.psave = 1'b1;
    end else begin
      r_next.psm_cnt = r_reg.psm_cnt + PSM_CW'(1);
    end
    // EN low: shutdown, registers and bus front end reset
    if (!en) begin
      r_next.colour = {NUM_CH{COLOUR_RST}};
      r_next.bright = {NUM_MOD{BRIGHT_RST}};
      r_next.ready = 1'b0;
      r_next.en_cnt = '0;
      r_next.rdata = 8'h00;
      r_next.out = '0;
      r_next.psm_cnt = '0;
      r_next.psave = 1'b0;
    end
  end

  // ==========================================
  // State register
  // ==========================================
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      r_reg <= '0;
      r_reg.bright <= {NUM_MOD{BRIGHT_RST}};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign REG_RDATA = r_reg.rdata;
  assign BUS_READY = r_reg.ready;
  assign BUS_RESET = !r_reg.en_sync[1];
  assign POWER_SAVE = r_reg.psave;
  assign SINK_OUTPUT_CHANNEL = r_reg.out;

  // ==========================================
  // Checks
  // ==========================================
  // Channel 0 duty seen by the checks
  logic [7:0] chk_f0;
  logic [11:0] chk_d0;
  assign chk_f0 = bright_factor(r_reg.bright[0], LOG_SCALE_EN);
  assign chk_d0 = duty_of(r_reg.colour[0], chk_f0);

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  chk_bright_reset: assert property (
    !r_reg.en_sync[1] |=> r_reg.bright[NUM_MOD-1] == BRIGHT_RST)
    else $error("brightness not back to full after EN low");
  chk_colour_write: assert property (
    REG_STB && REG_WR && r_reg.ready && r_reg.en_sync[1]
      && REG_ADDR == COLOUR_BASE |=> r_reg.colour[0] == $past(REG_WDATA))
    else $error("colour write not stored");
  chk_bright_write: assert property (
    REG_STB && REG_WR && r_reg.ready && r_reg.en_sync[1]
      && REG_ADDR == BRIGHT_BASE |=> r_reg.bright[0] == $past(REG_WDATA))
    else $error("brightness write not stored");
  chk_full_duty: assert property (
    r_reg.colour[0] == 8'hff && r_reg.bright[0] == 8'hff
      |-> chk_d0 == 12'hfff)
    else $error("full-scale inputs not full duty");
  chk_lin_curve: assert property (
    !LOG_SCALE_EN |-> chk_f0 == r_reg.bright[0])
    else $error("linear scale not identity");
  chk_period_wrap: assert property (
    r_reg.cnt == PWM_LAST && r_reg.pre == PRE_LAST |=> r_reg.cnt == 9'h000)
    else $error("period counter not 512 steps");
  chk_width_on: assert property (
    r_reg.en_sync[1] && {1'b0, chk_d0[11:3]} > {1'b0, r_reg.cnt}
      |=> r_reg.out[0])
    else $error("channel off inside pulse width");
  chk_dither_off: assert property (
    r_reg.en_sync[1] && !DITHER_EN && chk_d0[11:3] == r_reg.cnt
      |=> !r_reg.out[0])
    else $error("fraction used with dither disabled");
  chk_psave_qual: assert property (
    $rose(r_reg.psave) |-> $past(r_reg.psm_cnt) == PSM_CW'(PSM_CYCLES - 1))
    else $error("power save entered before idle time");
  chk_psave_gate: assert property (
    !PSAVE_EN |=> !r_reg.psave)
    else $error("power save while disabled");
  chk_ready_delay: assert property (
    $rose(r_reg.ready) |-> $past(r_reg.en_cnt) == EN_CW'(EN_H_CYCLES - 1))
    else $error("bus ready at wrong time");
  chk_bus_reset: assert property (
    !EN ##1 !EN |=> BUS_RESET ##1 !BUS_READY)
    else $error("bus not reset after EN fall");

  cov_psave: cover property ($rose(r_reg.psave));
  cov_ready: cover property ($rose(r_reg.ready));
  cov_dither: cover property (DITHER_EN && chk_d0[2:0] != 3'h0
    && $rose(r_reg.out[0]));
  cov_write: cover property (REG_STB && REG_WR && r_reg.ready);
endmodule
`default_nettype wire

//--- shared/rcpd_pkg.sv
// Constants for the RGB channel PWM dimmer.
// Assumes a 200 MHz system clock and a byte-wide register port.
package rcpd_pkg;
  // ==========================================
  // Clock and channel counts
  // ==========================================
  localparam int unsigned SYS_HZ = 200_000_000;
  localparam int unsigned NUM_MOD = 8;
  localparam int unsigned NUM_CH = 3 * NUM_MOD;
  localparam int unsigned CH_LOW = 18;
  localparam int unsigned CH_HIGH = 24;
  localparam int unsigned COL_W = 8;
  localparam int unsigned DUTY_W = 12;
  localparam int unsigned PW_W = 9;
  localparam int unsigned DITH_W = 3;
  // ==========================================
  // PWM timing
  // ==========================================
  localparam int unsigned PWM_HZ = 29_000;
  localparam int unsigned PWM_STEPS = 512;
  localparam int unsigned PWM_DIV = SYS_HZ / (PWM_HZ * PWM_STEPS);
  localparam logic [3:0] PRE_LAST = 4'(PWM_DIV - 1);
  localparam logic [8:0] PWM_LAST = 9'(PWM_STEPS - 1);
  // ==========================================
  // Power-save and enable-pin timing
  // ==========================================
  localparam int unsigned PSM_MS = 30;
  localparam int unsigned PSM_CYC = SYS_HZ / 1000 * PSM_MS;
  localparam int unsigned EN_H_US = 500;
  localparam int unsigned EN_H_CYC = SYS_HZ / 1_000_000 * EN_H_US;
  localparam int unsigned EN_L_US = 3;
  localparam int unsigned EN_L_CYC = SYS_HZ / 1_000_000 * EN_L_US;
  localparam int unsigned PSM_CW = 23;
  localparam int unsigned EN_CW = 17;
  // ==========================================
  // Register map (byte registers)
  // ==========================================
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] BRIGHT_BASE = 6'h00;
  localparam logic [5:0] COLOUR_BASE = 6'h08;
  localparam logic [7:0] BRIGHT_RST = 8'hff;
  localparam logic [7:0] COLOUR_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage

//--- tb/rcpd_led_model.sv
// Far-side model: one LED string per sink output, counting lit clocks.
// Assumes the sink outputs are registered on the same clock it samples.
`timescale 1ns/1ps
`default_nettype none
module rcpd_led_model
  import rcpd_pkg::*;
(
  input wire logic clk,
  input wire logic meas_en,
  input wire logic [NUM_CH-1:0] sink,
  output var int on_cnt [NUM_CH]
);
  // ==========================================
  // Lit-time integrators
  // ==========================================
  // Clear while idle, so each window starts from zero
  always @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!meas_en) begin
        on_cnt[i] <= 0;
      end else if (sink[i]) begin
        on_cnt[i] <= on_cnt[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/rcpd_dimmer_tb.sv
// Self-checking bench for the RGB channel PWM dimmer.
// Assumes rcpd_pkg and the LED model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rcpd_dimmer_tb
  import rcpd_pkg::*;
;
  // ==========================================
  // Signals
  // ==========================================
  localparam int PER = PWM_DIV * PWM_STEPS; // Clocks per PWM period
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b0;
  logic stb = 1'b0;
  logic wr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic log_en = 1'b0;
  logic dith_en = 1'b1;
  logic ps_en = 1'b1;
  logic meas = 1'b0;
  logic [7:0] rdata;
  logic bus_ready, bus_reset, power_save;
  logic [NUM_CH-1:0] sink;
  int on_cnt [NUM_CH];
  int n_errors = 0;
  int cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  rcpd_dimmer #(.CHANNELS(24), .PSM_CYCLES(50), .EN_H_CYCLES(20)) u_rcpd_dimmer (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .EN(en), .REG_STB(stb), .REG_WR(wr),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .LOG_SCALE_EN(log_en),
    .DITHER_EN(dith_en), .PSAVE_EN(ps_en), .BUS_READY(bus_ready), .BUS_RESET(bus_reset),
    .POWER_SAVE(power_save), .SINK_OUTPUT_CHANNEL(sink));
  rcpd_led_model u_rcpd_led_model (.clk(clk_sys), .meas_en(meas), .sink(sink),
    .on_cnt(on_cnt));
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // One strobe; inputs move just after an edge
  task automatic reg_acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 stb = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clk_sys);
    #1 stb = 1'b0;
  endtask
  task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
    reg_acc(1'b0, a, 8'h00);
    check(32'(rdata), 32'(exp));
  endtask
  // Bounded wait on a flag; sel 0 ready, 1 bus reset, 2 power save
  task automatic wait_for(input int sel, input int lo, input int hi);
    for (int n = 1; n <= 1000; n++) begin
      @(posedge clk_sys);
      #1;
      if ((sel == 0 && bus_ready === 1'b1) || (sel == 1 && bus_reset === 1'b1) ||
          (sel == 2 && power_save === 1'b1)) begin
        check(32'(n >= lo && n <= hi), 32'h1);
        return;
      end
    end
    n_errors++;
    tally_and_finish();
  endtask
  // Integrate lit clocks over whole PWM periods
  task automatic measure(input int periods);
    repeat (20) @(posedge clk_sys);
    #1 meas = 1'b1;
    repeat (periods * PER) @(posedge clk_sys);
    #1 meas = 1'b0;
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_regs();
    reg_rd(6'h00, 8'hff);
    reg_rd(6'h07, 8'hff);
    reg_rd(6'h1f, 8'h00);
    reg_rd(6'h3f, 8'h00);
    reg_acc(1'b1, 6'h0b, 8'h80);
    reg_rd(6'h0b, 8'h80);
    reg_rd(6'h0c, 8'h00);
    reg_acc(1'b1, 6'h0b, 8'h00);
    // Channel 0 at full scale wakes the duty and write checks
    reg_acc(1'b1, 6'h08, 8'hff);
    reg_rd(6'h08, 8'hff);
    reg_acc(1'b1, 6'h00, 8'h5a);
    reg_rd(6'h00, 8'h5a);
    reg_acc(1'b1, 6'h00, 8'hff);
    reg_acc(1'b1, 6'h08, 8'h00);
  endtask
  task automatic t_psave();
    reg_rd(6'h08, 8'h00);
    wait_for(2, 48, 53);
    reg_rd(6'h08, 8'h00);
    check(32'(power_save), 32'h0);
    ps_en = 1'b0;
    repeat (80) @(posedge clk_sys);
    #1 check(32'(power_save), 32'h0);
    ps_en = 1'b1;
  endtask
  task automatic t_pwm();
    dith_en = 1'b0;
    reg_acc(1'b1, 6'h0b, 8'h80);
    reg_acc(1'b1, 6'h0e, 8'hff);
    reg_acc(1'b1, 6'h02, 8'h20);
    reg_acc(1'b1, 6'h1f, 8'hff);
    // Linear: duties 807, 201 and fff, fraction dropped
    measure(1);
    check(32'(on_cnt[0]), 32'd0);
    check(32'(on_cnt[3]), 32'(256 * 13));
    check(32'(on_cnt[6]), 32'(64 * 13));
    check(32'(on_cnt[23]), 32'(511 * 13));
    // Log curve maps 20 to factor 2; ff stays full
    log_en = 1'b1;
    measure(1);
    check(32'(on_cnt[6]), 32'(4 * 13));
    check(32'(on_cnt[23]), 32'(511 * 13));
    // Eight periods with dither average the full 12-bit duty
    log_en = 1'b0;
    dith_en = 1'b1;
    measure(8);
    check(32'(on_cnt[3]), 32'(2055 * 13));
    check(32'(on_cnt[6]), 32'(513 * 13));
    check(32'(on_cnt[23]), 32'(4095 * 13));
  endtask
  task automatic t_enable();
    @(posedge clk_sys);
    #1 en = 1'b0;
    wait_for(1, 1, 4);
    // Outputs clear one edge after the synchronised pin
    @(posedge clk_sys);
    #1 check(32'(sink), 32'h0);
    en = 1'b1;
    wait_for(0, 19, 24);
    reg_rd(6'h1f, 8'h00);
  endtask
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    @(posedge clk_sys);
    #1 check(32'(bus_reset), 32'h1);
    en = 1'b1;
    wait_for(0, 17, 23);
    t_regs();
    t_psave();
    t_pwm();
    t_enable();
    tally_and_finish();
  end
endmodule
`default_nettype wire
